// ==== rtl/timer2_pkg.sv ====
// shared constants for the split-capable sixteen-bit timer
package timer2_pkg;
   // -----------------------------------------------------------------
   // register offsets on the special-function register port
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_RELOAD_VALUE_LOW = 8'hCA;
   localparam logic [7:0] ADDR_RELOAD_VALUE_HIGH = 8'hCB;
   localparam logic [7:0] ADDR_COUNT_LOW_BYTE = 8'hCC;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_RELOAD_VALUE_LOW = 8'h00;
   localparam logic [7:0] RST_RELOAD_VALUE_HIGH = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;

   // -----------------------------------------------------------------
   // aux_clock_select encodings and divider counts
   // -----------------------------------------------------------------
   localparam logic [1:0] SEL_SYSDIV_RTCCAP = 2'h0;
   localparam logic [1:0] SEL_COMP_RTCCAP = 2'h1;
   localparam logic [1:0] SEL_SYSDIV_COMPCAP = 2'h2;
   localparam logic [1:0] SEL_RTC_COMPCAP = 2'h3;
   localparam int SYS_DIVIDE = 12;
   localparam int RTC_DIVIDE = 8;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;
endpackage : timer2_pkg

// ==== rtl/tick_if.sv ====
// count and capture tick pulses passed from the source to the counter
`timescale 1ns/1ps
interface tick_if;
   logic aux_tick;
   logic cap_tick;
   modport source (output aux_tick, output cap_tick);
   modport sink (input aux_tick, input cap_tick);
endinterface : tick_if

// ==== rtl/tick_source.sv ====
// synchronises slow sources and decodes the auxiliary and capture ticks
`timescale 1ns/1ps
module tick_source import timer2_pkg::*; (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic [1:0] i_aux_clock_select,
   input wire logic i_comparator0,
   input wire logic i_rtc_clock,
   tick_if.source ticks
);
   typedef struct packed {
      logic comp_s1;
      logic comp_s2;
      logic comp_s3;
      logic rtc_s1;
      logic rtc_s2;
      logic rtc_s3;
      logic [3:0] div12;
      logic [2:0] rtc_div;
      logic aux_tick;
      logic cap_tick;
   } src_state_t;

   src_state_t s_r;
   src_state_t s_nxt;
   logic comp_edge;
   logic rtc_edge;
   logic rtc8_pulse;
   logic sys12_pulse;

   // -----------------------------------------------------------------
   // edge detection and decode
   // -----------------------------------------------------------------
   // edges are taken between the second and third stage only
   assign comp_edge = s_r.comp_s2 & ~s_r.comp_s3;
   assign rtc_edge = s_r.rtc_s2 & ~s_r.rtc_s3;
   assign rtc8_pulse = rtc_edge && (s_r.rtc_div == 3'(RTC_DIVIDE - 1));
   assign sys12_pulse = (s_r.div12 == 4'(SYS_DIVIDE - 1));

   // next state: synchronisers, dividers and tick selection
   always_comb begin
      s_nxt = s_r;
      s_nxt.comp_s1 = i_comparator0;
      s_nxt.comp_s2 = s_r.comp_s1;
      s_nxt.comp_s3 = s_r.comp_s2;
      s_nxt.rtc_s1 = i_rtc_clock;
      s_nxt.rtc_s2 = s_r.rtc_s1;
      s_nxt.rtc_s3 = s_r.rtc_s2;
      s_nxt.div12 = sys12_pulse ? 4'h0 : 4'(s_r.div12 + 4'h1);
      if (rtc_edge) begin
         s_nxt.rtc_div = 3'(s_r.rtc_div + 3'h1);
      end
      // one field picks both sources; split bytes share the result
      case (i_aux_clock_select)
         SEL_SYSDIV_RTCCAP: begin
            s_nxt.aux_tick = sys12_pulse;
            s_nxt.cap_tick = rtc8_pulse;
         end
         SEL_COMP_RTCCAP: begin
            s_nxt.aux_tick = comp_edge;
            s_nxt.cap_tick = rtc8_pulse;
         end
         SEL_SYSDIV_COMPCAP: begin
            s_nxt.aux_tick = sys12_pulse;
            s_nxt.cap_tick = comp_edge;
         end
         default: begin
            s_nxt.aux_tick = rtc8_pulse;
            s_nxt.cap_tick = comp_edge;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ticks.aux_tick = s_r.aux_tick;
   assign ticks.cap_tick = s_r.cap_tick;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_comp_aux_tick: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_aux_clock_select == SEL_COMP_RTCCAP) ##1 (i_aux_clock_select == SEL_COMP_RTCCAP)
      |-> (s_r.aux_tick == $past(comp_edge)))
      else $error("aux tick does not follow comparator edge");
   a_comp_cap_tick: assert property (@(posedge i_clock) disable iff (i_reset)
      $past(i_aux_clock_select[1]) |-> (s_r.cap_tick == $past(comp_edge)))
      else $error("capture tick does not follow comparator edge");
endmodule : tick_source

// ==== rtl/timer2_run_clock_reload.sv ====
// split-capable sixteen-bit auto-reload timer: run, clocking, reload, low count
`timescale 1ns/1ps
module timer2_run_clock_reload import timer2_pkg::*; (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_write,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_run_control_bit,
   input wire logic i_split_mode_enable,
   input wire logic i_capture_mode_enable,
   input wire logic [1:0] i_aux_clock_select,
   input wire logic i_high_byte_clock_pick,
   input wire logic i_low_byte_clock_pick,
   input wire logic i_comparator0,
   input wire logic i_rtc_clock,
   input wire logic i_high_flag_clear,
   input wire logic i_low_flag_clear,
   input wire logic i_count_high_write,
   input wire logic [7:0] i_count_high_wdata,
   output logic [7:0] o_sfr_rdata,
   output logic [7:0] o_count_high_byte,
   output logic o_high_overflow_flag,
   output logic o_low_overflow_flag
);
   typedef struct packed {
      logic [7:0] reload_lo;
      logic [7:0] reload_hi;
      logic [15:0] cnt;
      logic flag_hi;
      logic flag_lo;
      logic [7:0] rdata;
   } tmr_state_t;

   tmr_state_t s_r;
   tmr_state_t s_nxt;
   tick_if ticks ();
   logic tick_lo;
   logic tick_hi;
   logic wr_rl_lo;
   logic wr_rl_hi;
   logic wr_cnt_lo;
   logic capture;

   // -----------------------------------------------------------------
   // tick generation
   // -----------------------------------------------------------------
   tick_source u_tick_source (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_aux_clock_select(i_aux_clock_select),
      .i_comparator0(i_comparator0),
      .i_rtc_clock(i_rtc_clock),
      .ticks(ticks)
   );

   // pick bit set means every system clock edge counts
   assign tick_lo = i_low_byte_clock_pick | ticks.aux_tick;
   assign tick_hi = i_high_byte_clock_pick | ticks.aux_tick;
   assign wr_rl_lo = i_sfr_write && (i_sfr_addr == ADDR_RELOAD_VALUE_LOW);
   assign wr_rl_hi = i_sfr_write && (i_sfr_addr == ADDR_RELOAD_VALUE_HIGH);
   assign wr_cnt_lo = i_sfr_write && (i_sfr_addr == ADDR_COUNT_LOW_BYTE);
   assign capture = i_capture_mode_enable && ticks.cap_tick;

   // -----------------------------------------------------------------
   // counting, reload, capture and register access
   // -----------------------------------------------------------------
   // clears are applied first so a same-cycle overflow still sets the flag
   always_comb begin
      s_nxt = s_r;
      if (i_high_flag_clear) begin
         s_nxt.flag_hi = 1'b0;
      end
      if (i_low_flag_clear) begin
         s_nxt.flag_lo = 1'b0;
      end
      if (!i_split_mode_enable) begin
         // sixteen-bit mode uses the low pick for the whole word
         if (i_run_control_bit && tick_lo) begin
            if (s_r.cnt == WORD_MAX) begin
               s_nxt.cnt = {s_r.reload_hi, s_r.reload_lo};
               s_nxt.flag_hi = 1'b1;
               s_nxt.flag_lo = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt + 16'h0001;
               if (s_r.cnt[7:0] == BYTE_MAX) begin
                  s_nxt.flag_lo = 1'b1;
               end
            end
         end
      end else begin
         if (tick_lo) begin
            if (s_r.cnt[7:0] == BYTE_MAX) begin
               s_nxt.cnt[7:0] = s_r.reload_lo;
               s_nxt.flag_lo = 1'b1;
            end else begin
               s_nxt.cnt[7:0] = s_r.cnt[7:0] + 8'h01;
            end
         end
         if (i_run_control_bit && tick_hi) begin
            if (s_r.cnt[15:8] == BYTE_MAX) begin
               s_nxt.cnt[15:8] = s_r.reload_hi;
               s_nxt.flag_hi = 1'b1;
            end else begin
               s_nxt.cnt[15:8] = s_r.cnt[15:8] + 8'h01;
            end
         end
      end
      // capture snapshots the count into the reload pair; software write wins
      if (capture) begin
         s_nxt.reload_lo = s_r.cnt[7:0];
         s_nxt.reload_hi = s_r.cnt[15:8];
         s_nxt.flag_hi = 1'b1;
      end
      if (wr_rl_lo) begin
         s_nxt.reload_lo = i_sfr_wdata;
      end
      if (wr_rl_hi) begin
         s_nxt.reload_hi = i_sfr_wdata;
      end
      if (wr_cnt_lo) begin
         s_nxt.cnt[7:0] = i_sfr_wdata;
      end
      if (i_count_high_write) begin
         s_nxt.cnt[15:8] = i_count_high_wdata;
      end
      // read data is registered, so it lags the address by one cycle
      case (i_sfr_addr)
         ADDR_RELOAD_VALUE_LOW: s_nxt.rdata = s_r.reload_lo;
         ADDR_RELOAD_VALUE_HIGH: s_nxt.rdata = s_r.reload_hi;
         ADDR_COUNT_LOW_BYTE: s_nxt.rdata = s_r.cnt[7:0];
         default: s_nxt.rdata = RDATA_UNMAPPED;
      endcase
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         s_r.reload_lo <= RST_RELOAD_VALUE_LOW;
         s_r.reload_hi <= RST_RELOAD_VALUE_HIGH;
         s_r.cnt <= RST_COUNT;
         s_r.flag_hi <= 1'b0;
         s_r.flag_lo <= 1'b0;
         s_r.rdata <= RDATA_UNMAPPED;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_sfr_rdata = s_r.rdata;
   assign o_count_high_byte = s_r.cnt[15:8];
   assign o_high_overflow_flag = s_r.flag_hi;
   assign o_low_overflow_flag = s_r.flag_lo;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   a_run_stop_hold: assert property (
      !i_split_mode_enable && !i_run_control_bit && !wr_cnt_lo && !i_count_high_write
      |=> $stable(s_r.cnt))
      else $error("count moved while stopped in sixteen-bit mode");
   a_split_high_gate: assert property (
      i_split_mode_enable && !i_run_control_bit && !i_count_high_write
      |=> $stable(s_r.cnt[15:8]))
      else $error("upper byte moved while run control low");
   a_split_low_runs: assert property (
      i_split_mode_enable && !i_run_control_bit && tick_lo && !wr_cnt_lo
      && s_r.cnt[7:0] != BYTE_MAX |=> s_r.cnt[7:0] == $past(s_r.cnt[7:0]) + 8'h01)
      else $error("lower byte did not count in split mode");
   a_pick_every_clk: assert property (
      i_split_mode_enable && i_low_byte_clock_pick && !wr_cnt_lo
      && s_r.cnt[7:0] != BYTE_MAX |=> s_r.cnt[7:0] != $past(s_r.cnt[7:0]))
      else $error("system clock pick did not count");
   a_reload_wrap: assert property (
      !i_split_mode_enable && i_run_control_bit && tick_lo && s_r.cnt == WORD_MAX
      && !wr_cnt_lo && !i_count_high_write && !capture && !wr_rl_lo && !wr_rl_hi
      |=> s_r.cnt == {s_r.reload_hi, s_r.reload_lo} && s_r.flag_hi)
      else $error("overflow did not reload the count");
   a_high_flag_sticky: assert property (
      s_r.flag_hi && !i_high_flag_clear |=> s_r.flag_hi)
      else $error("high flag dropped without clear");
   a_low_flag_sets: assert property (
      tick_lo && s_r.cnt[7:0] == BYTE_MAX && !wr_cnt_lo
      && (i_split_mode_enable || i_run_control_bit) |=> s_r.flag_lo)
      else $error("low wrap did not set low flag");
   a_count_write_wins: assert property (
      wr_cnt_lo |=> s_r.cnt[7:0] == $past(i_sfr_wdata))
      else $error("count write lost");
   a_reload_store: assert property (
      wr_rl_lo ##1 1'b1 |-> s_r.reload_lo == $past(i_sfr_wdata))
      else $error("reload low write lost");
   a_capture_snap: assert property (
      capture && !wr_rl_lo && !wr_rl_hi
      |=> {s_r.reload_hi, s_r.reload_lo} == $past(s_r.cnt) && s_r.flag_hi)
      else $error("capture did not snapshot the count");
   a_read_low: assert property (
      i_sfr_addr == ADDR_COUNT_LOW_BYTE |=> o_sfr_rdata == $past(s_r.cnt[7:0]))
      else $error("low count read mismatch");

   c_wrap16: cover property (!i_split_mode_enable && s_r.cnt == WORD_MAX && tick_lo
      && i_run_control_bit);
   c_split_wrap: cover property (i_split_mode_enable && s_r.cnt[7:0] == BYTE_MAX && tick_lo);
   c_capture: cover property (capture);
   c_set_on_clear: cover property (i_low_flag_clear && tick_lo && s_r.cnt[7:0] == BYTE_MAX);
endmodule : timer2_run_clock_reload

// ==== verif/timer2_run_clock_reload_tb.sv ====
// self-checking bench for the split-capable timer block
`timescale 1ns/1ps
module timer2_run_clock_reload_tb;
   import timer2_pkg::*;
   logic clock, reset, wr_en, run, split, cap, pick_h, pick_l, comp, rtc, clr_h, clr_l, hw_en;
   logic [7:0] addr, wdata, hw_data, rdata, cnt_h, v0, v1, d;
   logic [1:0] sel;
   logic flag_h, flag_l;
   int err_total, checked;
   logic [1:0] sels [3] = '{2'h0, 2'h2, 2'h3};
   int wins [3] = '{118, 118, 798};

   timer2_run_clock_reload dut (.i_clock(clock), .i_reset(reset), .i_sfr_addr(addr),
      .i_sfr_write(wr_en), .i_sfr_wdata(wdata), .i_run_control_bit(run),
      .i_split_mode_enable(split), .i_capture_mode_enable(cap), .i_aux_clock_select(sel),
      .i_high_byte_clock_pick(pick_h), .i_low_byte_clock_pick(pick_l), .i_comparator0(comp),
      .i_rtc_clock(rtc), .i_high_flag_clear(clr_h), .i_low_flag_clear(clr_l),
      .i_count_high_write(hw_en), .i_count_high_wdata(hw_data), .o_sfr_rdata(rdata),
      .o_count_high_byte(cnt_h), .o_high_overflow_flag(flag_h),
      .o_low_overflow_flag(flag_l));

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // every input moves 1 ns after a rising edge so no race with sampling
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      addr = a;
      wdata = v;
      wr_en = 1'b1;
      step(1);
      wr_en = 1'b0;
      // one idle edge so a following write never re-raises the strobe in this time step
      step(1);
   endtask : wr

   // read data is registered, so two edges pass before it is taken
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      addr = a;
      step(2);
      v = rdata;
   endtask : rd

   task automatic wh(input logic [7:0] v);
      hw_data = v;
      hw_en = 1'b1;
      step(1);
      hw_en = 1'b0;
   endtask : wh

   task automatic clr();
      clr_h = 1'b1;
      clr_l = 1'b1;
      step(1);
      clr_h = 1'b0;
      clr_l = 1'b0;
   endtask : clr

   // eight-bit counter stepped n ticks, reloading on wrap
   function automatic logic [7:0] adv(input logic [7:0] v, input int n, input logic [7:0] rl);
      for (int i = 0; i < n; i++) v = (v == BYTE_MAX) ? rl : v + 8'h01;
      return v;
   endfunction : adv

   task automatic report_and_stop();
      if (err_total == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop

   // -----------------------------------------------------------------
   // clocks and watchdog
   // -----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // slow oscillator, ten system cycles a period, free running
   initial begin
      rtc = 1'b0;
      forever begin
         repeat (5) @(posedge clock);
         #1 rtc = ~rtc;
      end
   end

   // a hang counts as a mismatch rather than stalling the run
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      report_and_stop();
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      {wr_en, run, split, cap, pick_h, pick_l, comp, clr_h, clr_l, hw_en} = '0;
      addr = 8'h00;
      wdata = 8'h00;
      hw_data = 8'h00;
      sel = 2'h0;
      err_total = 0;
      checked = 0;
      reset = 1'b1;
      void'($urandom(37));
      repeat (5) @(posedge clock);
      #1 reset = 1'b0;
      // reset values; counting is stopped so the count is still zero
      rd(ADDR_RELOAD_VALUE_LOW, v0);
      chk(v0, 8'h00);
      rd(ADDR_RELOAD_VALUE_HIGH, v0);
      chk(v0, 8'h00);
      rd(ADDR_COUNT_LOW_BYTE, v0);
      chk(v0, 8'h00);
      chk(cnt_h, 8'h00);
      chk(8'({flag_h, flag_l}), 8'h00);
      // random back-to-back writes, with an unmapped address in between
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         wr(ADDR_RELOAD_VALUE_LOW, d);
         wr(ADDR_RELOAD_VALUE_HIGH, ~d);
         wr(8'h91, d);
         rd(ADDR_RELOAD_VALUE_LOW, v0);
         chk(v0, d);
         rd(ADDR_RELOAD_VALUE_HIGH, v0);
         chk(v0, ~d);
         rd(8'h91, v0);
         chk(v0, RDATA_UNMAPPED);
      end
      // stopped sixteen-bit count holds a written low byte
      pick_l = 1'b1;
      wr(ADDR_COUNT_LOW_BYTE, d);
      step(20);
      rd(ADDR_COUNT_LOW_BYTE, v0);
      chk(v0, d);
      // running on the system clock: one step per cycle
      run = 1'b1;
      rd(ADDR_COUNT_LOW_BYTE, v0);
      step(18);
      rd(ADDR_COUNT_LOW_BYTE, v1);
      chk(v1, v0 + 8'h14);
      // auxiliary clock sources, ten ticks in each divided-source window, five comparator edges in the last
      pick_l = 1'b0;
      foreach (sels[i]) begin
         sel = sels[i];
         step(10);
         rd(ADDR_COUNT_LOW_BYTE, v0);
         step(wins[i]);
         rd(ADDR_COUNT_LOW_BYTE, v1);
         chk(v1, v0 + 8'h0A);
      end
      sel = 2'h1;
      step(10);
      rd(ADDR_COUNT_LOW_BYTE, v0);
      for (int i = 0; i < 5; i++) begin
         comp = 1'b1;
         step(4);
         comp = 1'b0;
         step(4);
      end
      step(10);
      rd(ADDR_COUNT_LOW_BYTE, v1);
      chk(v1, v0 + 8'h05);
      // sixteen-bit wrap reloads both bytes and raises both flags
      run = 1'b0;
      pick_l = 1'b1;
      clr();
      wr(ADDR_RELOAD_VALUE_LOW, 8'h34);
      wr(ADDR_RELOAD_VALUE_HIGH, 8'h12);
      wr(ADDR_COUNT_LOW_BYTE, 8'hF0);
      wh(8'hFF);
      run = 1'b1;
      step(20);
      run = 1'b0;
      step(2);
      chk(cnt_h, 8'h12);
      rd(ADDR_COUNT_LOW_BYTE, v0);
      chk(v0, 8'h38);
      step(10);
      chk(8'({flag_h, flag_l}), 8'h03);
      clr();
      chk(8'({flag_h, flag_l}), 8'h00);
      // split: lower byte runs without run control, upper waits for it
      split = 1'b1;
      pick_h = 1'b1;
      wr(ADDR_RELOAD_VALUE_LOW, 8'hA0);
      wr(ADDR_RELOAD_VALUE_HIGH, 8'h80);
      wh(8'hF8);
      wr(ADDR_COUNT_LOW_BYTE, 8'hF0);
      rd(ADDR_COUNT_LOW_BYTE, v0);
      step(38);
      rd(ADDR_COUNT_LOW_BYTE, v1);
      chk(v1, adv(v0, 40, 8'hA0));
      chk(cnt_h, 8'hF8);
      chk(8'({flag_h, flag_l}), 8'h01);
      run = 1'b1;
      step(10);
      run = 1'b0;
      step(2);
      chk(cnt_h, adv(8'hF8, 10, 8'h80));
      chk(8'(flag_h), 8'h01);
      // capture: with select 10 the oscillator must not trigger it
      split = 1'b0;
      sel = 2'h2;
      clr();
      wr(ADDR_COUNT_LOW_BYTE, 8'h77);
      wh(8'h66);
      cap = 1'b1;
      step(100);
      rd(ADDR_RELOAD_VALUE_LOW, v0);
      chk(v0, 8'hA0);
      chk(8'(flag_h), 8'h00);
      comp = 1'b1;
      step(4);
      comp = 1'b0;
      step(12);
      rd(ADDR_RELOAD_VALUE_LOW, v0);
      chk(v0, 8'h77);
      rd(ADDR_RELOAD_VALUE_HIGH, v0);
      chk(v0, 8'h66);
      chk(8'(flag_h), 8'h01);
      // select 00: the divided oscillator triggers the snapshot
      sel = 2'h0;
      wr(ADDR_COUNT_LOW_BYTE, 8'h55);
      wh(8'h44);
      step(200);
      rd(ADDR_RELOAD_VALUE_LOW, v0);
      chk(v0, 8'h55);
      rd(ADDR_RELOAD_VALUE_HIGH, v0);
      chk(v0, 8'h44);
      // select 01 keeps the oscillator trigger, 11 hands it to the comparator
      sel = 2'h1;
      wr(ADDR_COUNT_LOW_BYTE, 8'h22);
      step(200);
      rd(ADDR_RELOAD_VALUE_LOW, v0);
      chk(v0, 8'h22);
      sel = 2'h3;
      wr(ADDR_COUNT_LOW_BYTE, 8'h99);
      step(200);
      rd(ADDR_RELOAD_VALUE_LOW, v0);
      chk(v0, 8'h22);
      comp = 1'b1;
      step(4);
      comp = 1'b0;
      step(12);
      rd(ADDR_RELOAD_VALUE_LOW, v0);
      chk(v0, 8'h99);
      report_and_stop();
   end
endmodule : timer2_run_clock_reload_tb
